// file: bdo_params.svh
// constants for the bundle decode and operand logic
`ifndef BDO_PARAMS_SVH
`define BDO_PARAMS_SVH

// ==========================================================
// word and address masks
`define BDO_WORD_MASK 32'hffffffff
`define BDO_WORD_ADDR_MASK 32'hfffffffc
`define BDO_HALF_ADDR_MASK 32'hfffffffe
`define BDO_INSTR_ADDR_MASK 32'hfffffff8
`define BDO_BLK16_ADDR_MASK 32'hfffffff0
`define BDO_BACKWARD_OFFSET 32'h80000000
`define BDO_BUNDLE_BYTES 32'h00000008

// ==========================================================
// register file
`define BDO_ZERO_REG 6'h3f
`define BDO_LINK_REG 6'h37

// ==========================================================
// bundle layout
`define BDO_MODE_BIT 63
`define BDO_T_MUL 23:0
`define BDO_T_ALU 47:24
`define BDO_T_MEM_OPC 62:60
`define BDO_T_MEM_SRCA 59:54
`define BDO_T_MEM_DEST 53:48
`define BDO_D_MUL_OPC 30:27
`define BDO_D_MUL_SIGN 26
`define BDO_D_MUL_BODY 26:0
`define BDO_D_MEM 62:31
`define BDO_TS_OPC 23:20
`define BDO_TS_BODY 19:0

// fields of a normalised 32-bit slot word
`define BDO_F_OPC 31:28
`define BDO_F_DEST 5:0
`define BDO_F_SRCA 11:6
`define BDO_F_SRCB 17:12
`define BDO_F_IMM8 19:12
`define BDO_F_SHAMT 16:12
`define BDO_F_SH_UNUSED 19:17
`define BDO_F_MM_LO 16:12
`define BDO_F_MM_HI 21:17
`define BDO_F_IMM16 27:12
`define BDO_F_SPR 26:12
`define BDO_F_JOFF 27:0

// ==========================================================
// opcodes
`define BDO_OP_NOP 4'h0
`define BDO_OP_LOAD 4'h1
`define BDO_OP_STORE 4'h2
`define BDO_OP_RRR 4'h3
`define BDO_OP_IMM8 4'h4
`define BDO_OP_SHIFT 4'h5
`define BDO_OP_UNARY 4'h6
`define BDO_OP_IMM16 4'h7
`define BDO_OP_MM 4'h8
`define BDO_OP_MUL 4'h9
`define BDO_OP_JB 4'ha
`define BDO_OP_JALB 4'hb
`define BDO_OP_JRP 4'hc
`define BDO_OP_MFSPR 4'hd
`define BDO_OP_MTSPR 4'he

// legal opcode sets per slot, bit n set = opcode n legal
`define BDO_LEGAL_T_MEM 16'h0007
`define BDO_LEGAL_T_ALU 16'h0079
`define BDO_LEGAL_T_MUL 16'h0279
`define BDO_LEGAL_D_MUL 16'h03f9
`define BDO_LEGAL_D_MEM 16'h7dff

// ==========================================================
// interrupt context save blocks in special register space
`define BDO_SAVE_BASE 15'h0100
`define BDO_SAVE_SIZE 15'h0004
`define BDO_SAVE_PC_OFF 15'h0000
`define BDO_SAVE_PL_OFF 15'h0001
`define BDO_SAVE_MASK_OFF 15'h0002

`endif

// file: bdo_pkg.sv
// types shared by the bundle decode and operand logic
package bdo_pkg;
   typedef enum logic [1:0] {
      BDO_SZ_BYTE,
      BDO_SZ_HALF,
      BDO_SZ_WORD,
      BDO_SZ_BLK16
   } bdo_size_t;

   typedef enum logic [1:0] {
      BDO_EXT_1,
      BDO_EXT_8,
      BDO_EXT_16,
      BDO_EXT_17
   } bdo_ext_t;
endpackage : bdo_pkg

// file: bdo_decode_core.sv
// bundle decode, register file and operand shaping for one core
`timescale 1ns/10ps
`default_nettype none
`include "bdo_params.svh"

// How it works
// - register 63 reads zero and silently drops every write.
// - sixty-four general registers, indices 0 through 63.
// - register 55 is the implicit link destination.
// - all words and results are 32 bits, full mask all ones.
// - bundles are 64 bits; fetch address low three bits cleared.
// - backward jump target adds a fixed constant to the offset.
// - memory byte lanes are little-endian.
// - plain half-word load is zero-extended to 32 bits.
// - plain byte load is zero-extended to 32 bits.
// - short immediates are 8-bit signed, sign-extended to 32.
// - sign extension from 16, 17 and 1 bit values.
// - shift formats carry dest, source and 5-bit count.
// - triple-form memory slot holds one load or store.
// - masked merge puts a bit range of one source into another.
// - word access clears low two bits, half word low one.
// - 16-byte block access clears low four bits.
// - special register index is 15 bits wide.
// - return stack: link jumps push, predicted returns pop.
// - one interrupt save block per protection level.
// - save block holds pc, protection level, mask at offsets.
// - bundle bit 63 picks triple (1) or dual (0) form.
// - triple slots: memory, alu, multiply-capable alu.
// - nonzero unused fields may raise illegal instruction.
module bdo_decode_core #(
   parameter int RS_DEPTH = 4,
   parameter int RS_PTR_W = 2,
   parameter bit STRICT_UNUSED = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic bundle_valid,
   input wire logic [63:0] bundle,
   input wire logic [31:0] bundle_pc,
   output var logic dec_valid_r,
   output var logic dec_triple_r,
   output var logic dec_illegal_r,
   output var logic [2:0][3:0] dec_op_r,
   output var logic [2:0][5:0] dec_dest_r,
   output var logic [2:0][5:0] dec_srca_r,
   output var logic [2:0][5:0] dec_srcb_r,
   output var logic [2:0][31:0] dec_imm_r,
   output var logic [2:0][4:0] dec_mm_lo_r,
   output var logic [2:0][4:0] dec_mm_hi_r,
   output var logic [31:0] fetch_addr_r,
   output var logic jump_valid_r,
   output var logic [31:0] jump_target_r,
   output var logic pred_valid_r,
   output var logic [31:0] pred_target_r,
   output var logic [14:0] spr_idx_r,
   input wire logic [5:0] rf_rd_idx_a,
   input wire logic [5:0] rf_rd_idx_b,
   output var logic [31:0] rf_rd_data_a_r,
   output var logic [31:0] rf_rd_data_b_r,
   input wire logic rf_wr_en,
   input wire logic [5:0] rf_wr_idx,
   input wire logic [31:0] rf_wr_data,
   input wire logic mem_req,
   input wire bdo_pkg::bdo_size_t mem_size,
   input wire logic mem_signed,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_rdata_raw,
   input wire logic [31:0] mem_wdata,
   output var logic mem_valid_r,
   output var logic [31:0] mem_addr_r,
   output var logic [3:0] mem_be_r,
   output var logic [31:0] mem_wdata_r,
   output var logic [31:0] ld_data_r,
   input wire bdo_pkg::bdo_ext_t ext_width,
   input wire logic [16:0] ext_val,
   output var logic [31:0] ext_data_r,
   input wire logic [31:0] mm_a,
   input wire logic [31:0] mm_b,
   input wire logic [4:0] mm_lo,
   input wire logic [4:0] mm_hi,
   output var logic [31:0] mm_res_r,
   input wire logic irq_enter,
   input wire logic [1:0] irq_pl,
   output var logic save_valid_r,
   output var logic [14:0] save_pc_idx_r,
   output var logic [14:0] save_pl_idx_r,
   output var logic [14:0] save_mask_idx_r
);

   // ==========================================================
   // shared functions

   // sign-extends the low w bits of v, w from 1 to 17
   function automatic logic [31:0] bdo_sext(input logic [16:0] v,
                                            input logic [5:0] w);
      logic [31:0] t;
      t = {v, 15'h0000} << (6'd17 - w);
      bdo_sext = 32'($signed(t) >>> (6'd32 - w));
   endfunction : bdo_sext

   // bits lo..hi set; lo above hi wraps round the top
   function automatic logic [31:0] bdo_range(input logic [4:0] lo,
                                             input logic [4:0] hi);
      logic [31:0] up;
      logic [31:0] dn;
      up = `BDO_WORD_MASK << lo;
      dn = `BDO_WORD_MASK >> (5'd31 - hi);
      bdo_range = (lo <= hi) ? (up & dn) : (up | dn);
   endfunction : bdo_range

   // reads a register with the zero register forced to zero
   function automatic logic [31:0] bdo_rd(input logic [63:0][31:0] f,
                                          input logic [5:0] i);
      bdo_rd = (i == `BDO_ZERO_REG) ? 32'h00000000 : f[i];
   endfunction : bdo_rd

   // ==========================================================
   // slot extraction
   wire logic triple = bundle[`BDO_MODE_BIT];
   wire logic [23:0] t_mul = bundle[`BDO_T_MUL];
   wire logic [23:0] t_alu = bundle[`BDO_T_ALU];
   logic [2:0][31:0] slot;
   logic [2:0][15:0] legal_set;

   // slot 2 memory, slot 1 alu, slot 0 multiply-capable
   always_comb begin
      if (triple) begin
         slot[0] = {t_mul[`BDO_TS_OPC], 8'h00, t_mul[`BDO_TS_BODY]};
         slot[1] = {t_alu[`BDO_TS_OPC], 8'h00, t_alu[`BDO_TS_BODY]};
         // memory slot has room for load or store only
         slot[2] = {1'b0, bundle[`BDO_T_MEM_OPC], 16'h0000,
                    bundle[`BDO_T_MEM_SRCA],
                    bundle[`BDO_T_MEM_DEST]};
         legal_set[0] = `BDO_LEGAL_T_MUL;
         legal_set[1] = `BDO_LEGAL_T_ALU;
         legal_set[2] = `BDO_LEGAL_T_MEM;
      end else begin
         // dual multiply slot is one bit short: imm16 top is replicated
         slot[0] = {bundle[`BDO_D_MUL_OPC], bundle[`BDO_D_MUL_SIGN],
                    bundle[`BDO_D_MUL_BODY]};
         slot[1] = 32'h00000000;
         slot[2] = bundle[`BDO_D_MEM];
         legal_set[0] = `BDO_LEGAL_D_MUL;
         legal_set[1] = 16'h0001;
         legal_set[2] = `BDO_LEGAL_D_MEM;
      end
   end

   // ==========================================================
   // per-slot field decode
   logic [2:0][3:0] op;
   logic [2:0][5:0] dest;
   logic [2:0][5:0] srcb;
   logic [2:0][31:0] imm;
   logic [2:0] bad;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_slot
         wire logic [31:0] s = slot[gi];
         wire logic [3:0] o = s[`BDO_F_OPC];
         wire logic unused_nz = STRICT_UNUSED &&
            (o == `BDO_OP_SHIFT) && (s[`BDO_F_SH_UNUSED] != 3'h0);
         assign op[gi] = o;
         assign bad[gi] = !legal_set[gi][o] || unused_nz;
         // link jumps write the implicit link register
         assign dest[gi] = (o == `BDO_OP_JALB) ? `BDO_LINK_REG :
            (o == `BDO_OP_STORE) ? `BDO_ZERO_REG : s[`BDO_F_DEST];
         assign srcb[gi] = (o == `BDO_OP_STORE) ? s[`BDO_F_DEST] :
            s[`BDO_F_SRCB];
         always_comb begin
            case (o)
               `BDO_OP_IMM8:
                  imm[gi] = bdo_sext({9'h000, s[`BDO_F_IMM8]},
                                     6'd8);
               `BDO_OP_IMM16:
                  imm[gi] = bdo_sext({1'b0, s[`BDO_F_IMM16]},
                                     6'd16);
               `BDO_OP_SHIFT:
                  imm[gi] = {27'h0000000, s[`BDO_F_SHAMT]};
               default:
                  imm[gi] = 32'h00000000;
            endcase
         end
      end
   endgenerate

   // ==========================================================
   // control transfer and return prediction
   wire logic [3:0] mop = op[2];
   wire logic [31:0] pc_al = bundle_pc & `BDO_INSTR_ADDR_MASK;
   wire logic is_jb = !triple &&
      (mop == `BDO_OP_JB || mop == `BDO_OP_JALB);
   wire logic [31:0] joff = {slot[2][`BDO_F_JOFF], 3'h0} +
      `BDO_BACKWARD_OFFSET;
   wire logic [31:0] jtgt = pc_al + joff;
   wire logic do_push = bundle_valid && !triple && mop == `BDO_OP_JALB;
   wire logic do_pop = bundle_valid && !triple && mop == `BDO_OP_JRP;

   logic [RS_DEPTH-1:0][31:0] rs_r;
   logic [RS_PTR_W-1:0] rs_ptr_r;
   logic [RS_PTR_W:0] rs_cnt_r;
   wire logic [RS_PTR_W-1:0] rs_top = rs_ptr_r - 1'b1;
   wire logic [RS_PTR_W:0] rs_full = (RS_PTR_W+1)'(RS_DEPTH);

   // push overwrites the oldest entry once full; pop of empty gives none
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rs_ptr_r <= '0;
         rs_cnt_r <= '0;
      end else if (ce && do_push) begin
         rs_r[rs_ptr_r] <= pc_al + `BDO_BUNDLE_BYTES;
         rs_ptr_r <= rs_ptr_r + 1'b1;
         rs_cnt_r <= (rs_cnt_r == rs_full) ? rs_cnt_r : rs_cnt_r + 1'b1;
      end else if (ce && do_pop && rs_cnt_r != '0) begin
         rs_ptr_r <= rs_top;
         rs_cnt_r <= rs_cnt_r - 1'b1;
      end
   end

   // ==========================================================
   // decode result registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dec_valid_r <= 1'b0;
         dec_triple_r <= 1'b0;
         dec_illegal_r <= 1'b0;
         dec_op_r <= '0;
         dec_dest_r <= '0;
         dec_srca_r <= '0;
         dec_srcb_r <= '0;
         dec_imm_r <= '0;
         dec_mm_lo_r <= '0;
         dec_mm_hi_r <= '0;
         fetch_addr_r <= 32'h00000000;
         jump_valid_r <= 1'b0;
         jump_target_r <= 32'h00000000;
         pred_valid_r <= 1'b0;
         pred_target_r <= 32'h00000000;
         spr_idx_r <= 15'h0000;
      end else if (ce) begin
         dec_valid_r <= bundle_valid;
         dec_triple_r <= triple;
         dec_illegal_r <= bundle_valid && (|bad);
         dec_op_r <= op;
         dec_dest_r <= dest;
         for (int k = 0; k < 3; k++) begin
            dec_srca_r[k] <= slot[k][`BDO_F_SRCA];
            dec_mm_lo_r[k] <= slot[k][`BDO_F_MM_LO];
            dec_mm_hi_r[k] <= slot[k][`BDO_F_MM_HI];
         end
         dec_srcb_r <= srcb;
         dec_imm_r <= imm;
         fetch_addr_r <= pc_al;
         jump_valid_r <= bundle_valid && is_jb;
         jump_target_r <= jtgt;
         pred_valid_r <= do_pop && rs_cnt_r != '0;
         pred_target_r <= rs_r[rs_top];
         spr_idx_r <= slot[2][`BDO_F_SPR];
      end
   end

   // ==========================================================
   // general register file
   logic [63:0][31:0] rf_r;
   wire logic rf_wr_ok = rf_wr_en && rf_wr_idx != `BDO_ZERO_REG;

   always_ff @(posedge clk) begin
      if (ce && rf_wr_ok) begin
         rf_r[rf_wr_idx] <= rf_wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rf_rd_data_a_r <= 32'h00000000;
         rf_rd_data_b_r <= 32'h00000000;
      end else if (ce) begin
         rf_rd_data_a_r <= bdo_rd(rf_r, rf_rd_idx_a);
         rf_rd_data_b_r <= bdo_rd(rf_r, rf_rd_idx_b);
      end
   end

   // ==========================================================
   // memory lanes, alignment and load extension
   wire logic [1:0] lane = mem_addr[1:0];
   logic [31:0] addr_al;
   logic [3:0] be;
   logic [31:0] ld_ext;
   // little-endian: byte at address offset n sits on lane n
   wire logic [31:0] ld_sh = mem_rdata_raw >> {lane, 3'h0};
   wire logic [31:0] wr_sh = mem_wdata << {lane, 3'h0};

   always_comb begin
      case (mem_size)
         bdo_pkg::BDO_SZ_BYTE: begin
            addr_al = mem_addr;
            be = 4'h1 << lane;
            ld_ext = mem_signed ? bdo_sext({9'h000, ld_sh[7:0]}, 6'd8) :
               {24'h000000, ld_sh[7:0]};
         end
         bdo_pkg::BDO_SZ_HALF: begin
            addr_al = mem_addr & `BDO_HALF_ADDR_MASK;
            be = lane[1] ? 4'hc : 4'h3;
            ld_ext = mem_signed ?
               bdo_sext({1'b0, ld_sh[15:0]}, 6'd16) :
               {16'h0000, ld_sh[15:0]};
         end
         bdo_pkg::BDO_SZ_WORD: begin
            addr_al = mem_addr & `BDO_WORD_ADDR_MASK;
            be = 4'hf;
            ld_ext = mem_rdata_raw & `BDO_WORD_MASK;
         end
         default: begin
            addr_al = mem_addr & `BDO_BLK16_ADDR_MASK;
            be = 4'hf;
            ld_ext = mem_rdata_raw;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_valid_r <= 1'b0;
         mem_addr_r <= 32'h00000000;
         mem_be_r <= 4'h0;
         mem_wdata_r <= 32'h00000000;
         ld_data_r <= 32'h00000000;
      end else if (ce) begin
         mem_valid_r <= mem_req;
         mem_addr_r <= addr_al;
         mem_be_r <= mem_req ? be : 4'h0;
         mem_wdata_r <= wr_sh;
         ld_data_r <= ld_ext;
      end
   end

   // ==========================================================
   // sign extension, masked merge and interrupt save indices
   logic [5:0] ext_w;
   always_comb begin
      case (ext_width)
         bdo_pkg::BDO_EXT_1: ext_w = 6'd1;
         bdo_pkg::BDO_EXT_8: ext_w = 6'd8;
         bdo_pkg::BDO_EXT_16: ext_w = 6'd16;
         default: ext_w = 6'd17;
      endcase
   end

   wire logic [31:0] mm_mask = bdo_range(mm_lo, mm_hi);
   // bits lo..hi come from a, the rest keep b
   wire logic [31:0] mm_res = (mm_a & mm_mask) | (mm_b & ~mm_mask);
   wire logic [14:0] save_blk = `BDO_SAVE_BASE +
      15'(irq_pl) * `BDO_SAVE_SIZE;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_data_r <= 32'h00000000;
         mm_res_r <= 32'h00000000;
         save_valid_r <= 1'b0;
         save_pc_idx_r <= 15'h0000;
         save_pl_idx_r <= 15'h0000;
         save_mask_idx_r <= 15'h0000;
      end else if (ce) begin
         ext_data_r <= bdo_sext(ext_val, ext_w);
         mm_res_r <= mm_res;
         save_valid_r <= irq_enter;
         save_pc_idx_r <= save_blk + `BDO_SAVE_PC_OFF;
         save_pl_idx_r <= save_blk + `BDO_SAVE_PL_OFF;
         save_mask_idx_r <= save_blk + `BDO_SAVE_MASK_OFF;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_link_jump;
      ce && do_push;
   endsequence

   a_zero_reg_read: assert property (
      ce && rf_rd_idx_a == `BDO_ZERO_REG |=> rf_rd_data_a_r == 32'h0)
      else $error("zero register read back nonzero");
   a_link_dest: assert property (
      ce && bundle_valid && !triple && mop == `BDO_OP_JALB
      |=> dec_dest_r[2] == `BDO_LINK_REG)
      else $error("link jump did not target link register");
   a_fetch_align: assert property (
      $past(ce) |-> fetch_addr_r[2:0] == 3'h0 &&
      fetch_addr_r[31:3] == $past(bundle_pc[31:3]))
      else $error("fetch address not bundle aligned");
   a_back_jump: assert property (
      ce && bundle_valid && is_jb |=> jump_valid_r &&
      jump_target_r - fetch_addr_r ==
      $past(joff))
      else $error("backward jump target wrong");
   a_byte_zext: assert property (
      ce && mem_size == bdo_pkg::BDO_SZ_BYTE && !mem_signed
      |=> ld_data_r[31:8] == 24'h0)
      else $error("plain byte load not zero extended");
   a_imm8_sext: assert property (
      ce && op[0] == `BDO_OP_IMM8
      |=> dec_imm_r[0] == {{24{$past(slot[0][19])}}, $past(slot[0][19:12])})
      else $error("short immediate not sign extended");
   a_triple_mem: assert property (
      ce && bundle_valid && triple && !(op[2] inside
      {`BDO_OP_NOP, `BDO_OP_LOAD, `BDO_OP_STORE}) |=> dec_illegal_r)
      else $error("non memory op in memory slot accepted");
   a_ret_predict: assert property (
      s_link_jump ##1 (ce && do_pop && !do_push)
      |=> pred_valid_r && pred_target_r == $past(fetch_addr_r) +
      `BDO_BUNDLE_BYTES)
      else $error("return prediction did not match last push");
   a_save_block: assert property (
      ce && irq_enter |=> save_valid_r && save_pl_idx_r ==
      `BDO_SAVE_BASE + 15'($past(irq_pl)) * `BDO_SAVE_SIZE +
      `BDO_SAVE_PL_OFF)
      else $error("save block index wrong");

endmodule : bdo_decode_core
`default_nettype wire

// file: bdo_mem_model.sv
// memory-side model feeding raw little-endian words to the core
`timescale 1ns/10ps
`default_nettype none
module bdo_mem_model (
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output var logic [31:0] mem_rdata_raw
);
   // ==========
   // byte pattern
   // lowest address sits in the lowest lane; an idle bus shows no stale word
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         mem_rdata_raw[8*i +: 8] = (8'h91 + 8'h25 *
            {mem_addr[5:2], 2'(i)}) ^ {8{!mem_req}};
      end
   end
endmodule : bdo_mem_model
`default_nettype wire

// file: bundle_decode_operand_semantics_tb_top.sv
// self-checking bench for the bundle decode and operand core
`timescale 1ns/10ps
`default_nettype none
`include "bdo_params.svh"
module bundle_decode_operand_semantics_tb_top;
   typedef struct {int due; int sel; logic [31:0] exp;} bdo_note_t;
   logic clk, rst_n, ce, bundle_valid, rf_wr_en, mem_req, mem_signed;
   logic irq_enter, dec_valid_r, dec_triple_r, dec_illegal_r;
   logic jump_valid_r, pred_valid_r, mem_valid_r, save_valid_r;
   logic [63:0] bundle;
   logic [31:0] bundle_pc, rf_wr_data, mem_addr, mem_rdata_raw, mem_wdata;
   logic [31:0] mm_a, mm_b, fetch_addr_r, jump_target_r, pred_target_r;
   logic [31:0] rf_rd_data_a_r, rf_rd_data_b_r, mem_addr_r, ld_data_r;
   logic [31:0] ext_data_r, mm_res_r, last_pc, mem_wdata_r;
   logic [2:0][31:0] dec_imm_r;
   logic [2:0][5:0] dec_dest_r, dec_srca_r, dec_srcb_r;
   logic [5:0] rf_rd_idx_a, rf_rd_idx_b, rf_wr_idx;
   logic [5:0] regs [4] = '{6'h05, 6'h37, 6'h3f, 6'h00};
   logic [4:0] mm_lo, mm_hi;
   logic [16:0] ext_val;
   logic [1:0] irq_pl;
   logic [14:0] spr_idx_r, save_pc_idx_r, save_pl_idx_r, save_mask_idx_r;
   logic [3:0] mem_be_r;
   bdo_pkg::bdo_size_t mem_size;
   bdo_pkg::bdo_ext_t ext_width;
   int num_errors = 0;
   int check_count = 0;
   int cyc = 0;
   bdo_note_t notes[$];

   bdo_decode_core dut_u (.clk, .rst_n, .ce, .bundle_valid, .bundle,
      .bundle_pc, .dec_valid_r, .dec_triple_r, .dec_illegal_r, .dec_op_r(),
      .dec_dest_r, .dec_srca_r, .dec_srcb_r, .dec_imm_r,
      .dec_mm_lo_r(), .dec_mm_hi_r(), .fetch_addr_r, .jump_valid_r,
      .jump_target_r, .pred_valid_r, .pred_target_r, .spr_idx_r,
      .rf_rd_idx_a, .rf_rd_idx_b, .rf_rd_data_a_r, .rf_rd_data_b_r,
      .rf_wr_en, .rf_wr_idx, .rf_wr_data, .mem_req, .mem_size, .mem_signed,
      .mem_addr, .mem_rdata_raw, .mem_wdata, .mem_valid_r, .mem_addr_r,
      .mem_be_r, .mem_wdata_r, .ld_data_r, .ext_width, .ext_val,
      .ext_data_r, .mm_a, .mm_b, .mm_lo, .mm_hi, .mm_res_r, .irq_enter,
      .irq_pl, .save_valid_r, .save_pc_idx_r, .save_pl_idx_r,
      .save_mask_idx_r);
   bdo_mem_model mem_u (.mem_req, .mem_addr, .mem_rdata_raw);

   // ==========
   // scoreboard
   function automatic logic [31:0] observe(int sel);
      case (sel)
         0: return rf_rd_data_a_r;
         1: return rf_rd_data_b_r;
         2: return ld_data_r;
         3: return {28'h0000000, mem_be_r};
         4: return mem_addr_r;
         5: return ext_data_r;
         6: return mm_res_r;
         7: return fetch_addr_r;
         8: return jump_target_r;
         9: return {25'h0, save_valid_r, mem_valid_r, dec_valid_r,
                    dec_triple_r, dec_illegal_r, jump_valid_r, pred_valid_r};
         10: return pred_target_r;
         11: return {17'h0, spr_idx_r};
         12: return {17'h0, save_pc_idx_r};
         13: return {17'h0, save_pl_idx_r};
         14: return {17'h0, save_mask_idx_r};
         15: return dec_imm_r[1];
         16: return {31'h0, dec_illegal_r};
         18: return mem_wdata_r;
         19: return {20'h0, dec_srcb_r[2], dec_srca_r[2]};
         default: return {26'h0, dec_dest_r[2]};
      endcase
   endfunction : observe

   task automatic check(logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic note(int sel, logic [31:0] exp);
      notes.push_back('{cyc + 1, sel, exp});
   endtask : note

   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   task automatic issue(logic [63:0] b);
      step();
      last_pc = $urandom;
      {bundle_valid, bundle, bundle_pc} = {1'b1, b, last_pc};
      note(7, last_pc & `BDO_INSTR_ADDR_MASK);
   endtask : issue

   task automatic stop_test();
      $display("errors=%0d checks=%0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // a hang costs at most this many cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc > 2000) begin
         num_errors++;
         stop_test();
      end
   end

   always @(posedge clk) begin
      #2;
      while (notes.size() > 0 && notes[0].due <= cyc) begin
         check(observe(notes[0].sel), notes[0].exp);
         void'(notes.pop_front());
      end
   end

   // ==========
   // stimulus
   initial begin
      logic [31:0] a, d, e, w, s, m;
      logic [3:0] be;
      logic [14:0] o;
      logic [63:0] b;
      logic [15:0] lm;
      {rst_n, ce, bundle_valid, rf_wr_en, mem_req, mem_signed} = '0;
      {irq_enter, bundle, bundle_pc, rf_wr_data, mem_addr, mem_wdata} = '0;
      {mm_a, mm_b, rf_rd_idx_a, rf_wr_idx, mm_lo, mm_hi, ext_val} = '0;
      irq_pl = 2'h0;
      rf_rd_idx_b = `BDO_ZERO_REG;
      mem_size = bdo_pkg::BDO_SZ_BYTE;
      ext_width = bdo_pkg::BDO_EXT_1;
      void'($urandom(28));
      repeat (10) @(posedge clk);
      #1;
      {rst_n, ce} = 2'h3;
      foreach (regs[k]) begin
         d = $urandom;
         step();
         {rf_wr_en, rf_wr_idx, rf_wr_data} = {1'b1, regs[k], d};
         step();
         {rf_wr_en, rf_rd_idx_a} = {1'b0, regs[k]};
         note(0, regs[k] == `BDO_ZERO_REG ? 32'h0 : d);
         note(1, 32'h0);
      end
      for (int i = 0; i < 16; i++) begin
         step();
         a = $urandom;
         if (i % 4 == 1) a[0] = 1'b0;
         mem_size = bdo_pkg::bdo_size_t'(i % 4);
         {mem_req, mem_signed, mem_addr, mem_wdata} = {1'b1, i[2], a, a};
         for (int j = 0; j < 4; j++)
            w[8*j +: 8] = 8'h91 + 8'h25 * {a[5:2], 2'(j)};
         s = w >> (8 * a[1:0]);
         case (i % 4)
            0: {e, be, m} = {{24{i[2] & s[7]}}, s[7:0], 4'h1 << a[1:0],
                             `BDO_WORD_MASK};
            1: {e, be, m} = {{16{i[2] & s[15]}}, s[15:0],
                             a[1] ? 4'hc : 4'h3, `BDO_HALF_ADDR_MASK};
            2: {e, be, m} = {w, 4'hf, `BDO_WORD_ADDR_MASK};
            default: {e, be, m} = {w, 4'hf, `BDO_BLK16_ADDR_MASK};
         endcase
         note(2, e);
         note(3, {28'h0, be});
         note(4, a & m);
         note(18, a << (8 * a[1:0]));
         note(9, 32'h20);
      end
      step();
      mem_req = 1'b0;
      note(3, 32'h0);
      for (int i = 0; i < 8; i++) begin
         step();
         ext_width = bdo_pkg::bdo_ext_t'(i % 4);
         ext_val = 17'($urandom);
         case (i % 4)
            0: d = {32{ext_val[0]}};
            1: d = {{24{ext_val[7]}}, ext_val[7:0]};
            2: d = {{16{ext_val[15]}}, ext_val[15:0]};
            default: d = {{15{ext_val[16]}}, ext_val};
         endcase
         note(5, d);
      end
      // a frozen core must not pick up the new value
      step();
      {ce, ext_val} = {1'b0, ~ext_val};
      note(5, d);
      step();
      ce = 1'b1;
      for (int i = 0; i < 8; i++) begin
         step();
         {mm_a, mm_b, mm_lo, mm_hi} = {$urandom, $urandom, 10'($urandom)};
         for (int j = 0; j < 32; j++) begin
            e[j] = ((mm_lo <= mm_hi) ? (j >= mm_lo && j <= mm_hi)
                    : (j >= mm_lo || j <= mm_hi)) ? mm_a[j] : mm_b[j];
         end
         note(6, e);
      end
      for (int p = 0; p < 4; p++) begin
         step();
         {irq_enter, irq_pl} = {1'b1, 2'(p)};
         o = `BDO_SAVE_BASE + `BDO_SAVE_SIZE * 15'(p);
         note(12, {17'h0, o + `BDO_SAVE_PC_OFF});
         note(13, {17'h0, o + `BDO_SAVE_PL_OFF});
         note(14, {17'h0, o + `BDO_SAVE_MASK_OFF});
         note(9, 32'h40);
      end
      step();
      irq_enter = 1'b0;
      d = $urandom;
      issue({1'b0, 4'hc, 59'h0});
      note(9, 32'h10);
      issue({1'b0, 4'hb, d[27:0], 31'h0});
      note(9, 32'h12);
      note(17, {26'h0, `BDO_LINK_REG});
      note(19, {20'h0, d[17:12], d[11:6]});
      e = (last_pc & `BDO_INSTR_ADDR_MASK);
      note(8, e + {1'b0, d[27:0], 3'h0} + `BDO_BACKWARD_OFFSET);
      issue({1'b0, 4'hc, 59'h0});
      note(9, 32'h11);
      note(10, e + `BDO_BUNDLE_BYTES);
      issue({1'b0, 4'hc, 59'h0});
      note(9, 32'h10);
      issue({1'b1, 15'h0, 4'h4, d[7:0], 36'h0});
      note(15, {{24{d[7]}}, d[7:0]});
      issue({1'b1, 15'h0, 4'h5, 3'h0, d[4:0], 36'h0});
      note(15, {27'h0, d[4:0]});
      note(9, 32'h18);
      issue({1'b1, 15'h0, 4'h5, 3'h5, d[4:0], 36'h0});
      note(9, 32'h1c);
      issue({1'b0, 4'hd, 1'b0, d[14:0], 43'h0});
      note(11, {17'h0, d[14:0]});
      for (int sl = 0; sl < 5; sl++) begin
         for (int op = 0; op < 16; op++) begin
            b = {1'b1, 63'h0};
            case (sl)
               0: {b[62:60], lm} = {3'(op), `BDO_LEGAL_T_MEM};
               1: {b[47:44], lm} = {4'(op), `BDO_LEGAL_T_ALU};
               2: {b[23:20], lm} = {4'(op), `BDO_LEGAL_T_MUL};
               3: {b[63], b[30:27], lm} = {1'b0, 4'(op), `BDO_LEGAL_D_MUL};
               default: {b[63:59], lm} = {1'b0, 4'(op), `BDO_LEGAL_D_MEM};
            endcase
            issue(b);
            note(16, {31'h0, ~lm[sl ? op : op % 8]});
         end
      end
      step();
      {bundle_valid, bundle} = '0;
      note(9, 32'h0);
      repeat (3) step();
      stop_test();
   end
endmodule : bundle_decode_operand_semantics_tb_top
`default_nettype wire
